// ---- logic/gpc_top.sv ----
// Pin configuration bank for general-purpose pins 32 to 47 with AXI4-Lite access.
// Assumes pads are resolved outside from pad_out and pad_oe; pad_in is asynchronous.
//
// The implementer's own choice: the AXI4-Lite slave port.
`timescale 1ns/1ps

module gpc_top
  import gpc_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [DATA_W-1:0] s_axi_wdata,
  input wire logic [STRB_W-1:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [PIN_COUNT-1:0] pad_in,
  output logic [PIN_COUNT-1:0] pad_out,
  output logic [PIN_COUNT-1:0] pad_oe,
  output logic [PIN_COUNT-1:0] pin_irq
);

  typedef struct packed {
    logic [DATA_W-1:0] cfg_lo;
    logic [DATA_W-1:0] cfg_hi;
    logic [DATA_W-1:0] config_write_key;
    logic [UPPER_W-1:0] data_upper;
    logic [UPPER_W-1:0] output_enable_upper;
    logic aw_held;
    logic [ADDR_W-1:0] awaddr;
    logic w_held;
    logic [DATA_W-1:0] wdata;
    logic [STRB_W-1:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [DATA_W-1:0] rdata;
    logic [1:0] rresp;
    logic [PIN_COUNT-1:0] level_prev;
    logic [PIN_COUNT-1:0] irq;
    logic [PIN_COUNT-1:0] pad_out;
    logic [PIN_COUNT-1:0] pad_oe;
  } gpc_state_t;

  gpc_state_t st_q;
  gpc_state_t st_d;
  logic [PIN_COUNT-1:0] level;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Word-aligned compare of a bus address with a register offset
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
    hit = (a[ADDR_W-1:2] == off[ADDR_W-1:2]);
  endfunction : hit

  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    is_mapped = hit(a, OFF_CFG_32_39) || hit(a, OFF_CFG_40_47) || hit(a, OFF_WRITE_KEY)
      || hit(a, OFF_READ_UPPER) || hit(a, OFF_DATA_UPPER) || hit(a, OFF_OE_UPPER);
  endfunction : is_mapped

  // Byte-lane merge under write strobes
  function automatic logic [DATA_W-1:0] merge(
    input logic [DATA_W-1:0] old_v,
    input logic [DATA_W-1:0] new_v,
    input logic [STRB_W-1:0] strb
  );
    logic [DATA_W-1:0] r;
    r = old_v;
    for (int b = 0; b < STRB_W; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    merge = r;
  endfunction : merge

  // Four-bit group of pin i, highest pin in the top nibble
  function automatic logic [FIELD_W-1:0] pin_field(
    input logic [DATA_W-1:0] lo,
    input logic [DATA_W-1:0] hi,
    input int i
  );
    logic [DATA_W-1:0] r;
    r = (i < PINS_PER_REG) ? lo : hi;
    pin_field = r[(i % PINS_PER_REG)*FIELD_W +: FIELD_W];
  endfunction : pin_field

  ////////////////////////////////////////////////////////////////////////////
  // Pad input synchroniser

  gpc_pin_sync u_sync (
    .clk(clk),
    .reset_n(reset_n),
    .pad_in(pad_in),
    .level(level)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic

  always_comb begin
    logic aw_have;
    logic w_have;
    logic [ADDR_W-1:0] wa;
    logic [DATA_W-1:0] wd;
    logic [STRB_W-1:0] ws;
    logic [ADDR_W-1:0] ra;
    logic unlocked;
    logic [FIELD_W-1:0] f;
    gpc_drive_t drv;
    logic [PIN_COUNT-1:0] readable;
    logic [DATA_W-1:0] m;

    st_d = st_q;
    aw_have = st_q.aw_held || (s_axi_awvalid && st_q.awready);
    w_have = st_q.w_held || (s_axi_wvalid && st_q.wready);
    wa = st_q.aw_held ? st_q.awaddr : s_axi_awaddr;
    wd = st_q.w_held ? st_q.wdata : s_axi_wdata;
    ws = st_q.w_held ? st_q.wstrb : s_axi_wstrb;
    ra = s_axi_araddr;
    unlocked = (st_q.config_write_key == UNLOCK_KEY);
    readable = '0;
    f = '0;
    drv = DRIVE_OFF;
    m = '0;

    // Write channel capture
    if (s_axi_awvalid && st_q.awready) begin
      st_d.aw_held = 1'b1;
      st_d.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && st_q.wready) begin
      st_d.w_held = 1'b1;
      st_d.wdata = s_axi_wdata;
      st_d.wstrb = s_axi_wstrb;
    end
    if (st_q.bvalid && s_axi_bready) begin
      st_d.bvalid = 1'b0;
    end

    // Write execution once address and data are both present
    if (aw_have && w_have && !st_q.bvalid) begin
      st_d.aw_held = 1'b0;
      st_d.w_held = 1'b0;
      st_d.bvalid = 1'b1;
      st_d.bresp = is_mapped(wa) ? RESP_OKAY : RESP_SLVERR;
      if (hit(wa, OFF_CFG_32_39) && unlocked) begin
        st_d.cfg_lo = merge(st_q.cfg_lo, wd, ws);
      end
      if (hit(wa, OFF_CFG_40_47) && unlocked) begin
        st_d.cfg_hi = merge(st_q.cfg_hi, wd, ws);
      end
      if (hit(wa, OFF_WRITE_KEY)) begin
        st_d.config_write_key = merge(st_q.config_write_key, wd, ws);
      end
      if (hit(wa, OFF_DATA_UPPER)) begin
        m = merge({{(DATA_W-UPPER_W){1'b0}}, st_q.data_upper}, wd, ws);
        st_d.data_upper = m[UPPER_W-1:0];
      end
      if (hit(wa, OFF_OE_UPPER)) begin
        m = merge({{(DATA_W-UPPER_W){1'b0}}, st_q.output_enable_upper}, wd, ws);
        st_d.output_enable_upper = m[UPPER_W-1:0];
      end
    end
    st_d.awready = !st_d.aw_held && !st_d.bvalid;
    st_d.wready = !st_d.w_held && !st_d.bvalid;

    // Per-pin behaviour
    st_d.level_prev = level;
    for (int i = 0; i < PIN_COUNT; i++) begin
      f = pin_field(st_q.cfg_lo, st_q.cfg_hi, i);
      drv = gpc_drive_t'(f[DRV_LSB +: 2]);
      readable[i] = level[i] && (f[INMASK_BIT] == 1'b0);
      if (f[DIR_BIT] == falling_edge_irq) begin
        st_d.irq[i] = st_q.level_prev[i] && !level[i];
      end else begin
        st_d.irq[i] = !st_q.level_prev[i] && level[i];
      end
      unique case (drv)
        DRIVE_OFF: begin
          st_d.pad_out[i] = 1'b0;
          st_d.pad_oe[i] = 1'b0;
        end
        drive_both_levels: begin
          st_d.pad_out[i] = st_q.data_upper[i];
          st_d.pad_oe[i] = 1'b1;
        end
        drive_low_only: begin
          st_d.pad_out[i] = 1'b0;
          st_d.pad_oe[i] = !st_q.data_upper[i];
        end
        gated_drive: begin
          st_d.pad_out[i] = st_q.data_upper[i];
          st_d.pad_oe[i] = st_q.output_enable_upper[i];
        end
      endcase
    end

    // Read channel
    if (st_q.rvalid && s_axi_rready) begin
      st_d.rvalid = 1'b0;
      st_d.arready = 1'b1;
    end
    if (s_axi_arvalid && st_q.arready) begin
      st_d.arready = 1'b0;
      st_d.rvalid = 1'b1;
      st_d.rresp = is_mapped(ra) ? RESP_OKAY : RESP_SLVERR;
      st_d.rdata = '0;
      if (hit(ra, OFF_CFG_32_39)) begin
        st_d.rdata = st_q.cfg_lo;
      end
      if (hit(ra, OFF_CFG_40_47)) begin
        st_d.rdata = st_q.cfg_hi;
      end
      if (hit(ra, OFF_WRITE_KEY)) begin
        st_d.rdata = st_q.config_write_key;
      end
      if (hit(ra, OFF_READ_UPPER)) begin
        st_d.rdata = {{(DATA_W-PIN_COUNT){1'b0}}, readable};
      end
      if (hit(ra, OFF_DATA_UPPER)) begin
        st_d.rdata = {{(DATA_W-UPPER_W){1'b0}}, st_q.data_upper};
      end
      if (hit(ra, OFF_OE_UPPER)) begin
        st_d.rdata = {{(DATA_W-UPPER_W){1'b0}}, st_q.output_enable_upper};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_q <= '0;
      st_q.cfg_lo <= CFG_RESET;
      st_q.cfg_hi <= CFG_RESET;
      st_q.config_write_key <= KEY_RESET;
      st_q.data_upper <= UPPER_RESET;
      st_q.output_enable_upper <= UPPER_RESET;
      st_q.awready <= 1'b1;
      st_q.wready <= 1'b1;
      st_q.arready <= 1'b1;
      st_q.bresp <= RESP_OKAY;
      st_q.rresp <= RESP_OKAY;
    end else begin
      st_q <= st_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign s_axi_awready = st_q.awready;
  assign s_axi_wready = st_q.wready;
  assign s_axi_bvalid = st_q.bvalid;
  assign s_axi_bresp = st_q.bresp;
  assign s_axi_arready = st_q.arready;
  assign s_axi_rvalid = st_q.rvalid;
  assign s_axi_rdata = st_q.rdata;
  assign s_axi_rresp = st_q.rresp;
  assign pad_out = st_q.pad_out;
  assign pad_oe = st_q.pad_oe;
  assign pin_irq = st_q.irq;

endmodule : gpc_top

// ---- logic/gpc_pkg.sv ----
// Constants, register map and types for the pin configuration bank, pins 32 to 47.
// Assumes a 20 MHz clock and a 32-bit AXI4-Lite register bus.
package gpc_pkg;

  localparam int PIN_COUNT = 16;
  localparam int PINS_PER_REG = 8;
  localparam int FIELD_W = 4;
  localparam int UPPER_W = 18;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int STRB_W = 4;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFF_CFG_32_39 = 8'h50;
  localparam logic [ADDR_W-1:0] OFF_CFG_40_47 = 8'h54;
  localparam logic [ADDR_W-1:0] OFF_WRITE_KEY = 8'h60;
  localparam logic [ADDR_W-1:0] OFF_READ_UPPER = 8'h84;
  localparam logic [ADDR_W-1:0] OFF_DATA_UPPER = 8'h8C;
  localparam logic [ADDR_W-1:0] OFF_OE_UPPER = 8'hA4;

  // Field positions inside one four-bit pin group
  localparam int DIR_BIT = 3;
  localparam int DRV_LSB = 1;
  localparam int INMASK_BIT = 0;

  localparam logic [DATA_W-1:0] UNLOCK_KEY = 32'h0000_0073;
  localparam logic [DATA_W-1:0] CFG_RESET = 32'h0000_0000;
  localparam logic [DATA_W-1:0] KEY_RESET = 32'h0000_0000;
  localparam logic [UPPER_W-1:0] UPPER_RESET = 18'h0_0000;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  localparam logic rising_edge_irq = 1'b0;
  localparam logic falling_edge_irq = 1'b1;

  typedef enum logic [1:0] {
    DRIVE_OFF,
    drive_both_levels,
    drive_low_only,
    gated_drive
  } gpc_drive_t;

endpackage : gpc_pkg

// ---- logic/gpc_pin_sync.sv ----
// Three-stage synchroniser for the pad inputs with an agreement filter.
// Assumes pad levels are asynchronous to clk.
`timescale 1ns/1ps

module gpc_pin_sync
  import gpc_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [PIN_COUNT-1:0] pad_in,
  output logic [PIN_COUNT-1:0] level
);

  typedef struct packed {
    logic [PIN_COUNT-1:0] s1;
    logic [PIN_COUNT-1:0] s2;
    logic [PIN_COUNT-1:0] s3;
    logic [PIN_COUNT-1:0] stable;
  } gpc_sync_state_t;

  gpc_sync_state_t st_q;
  gpc_sync_state_t st_d;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    st_d = st_q;
    st_d.s1 = pad_in;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    // A level counts once stages two and three agree
    st_d.stable = (st_q.s2 & st_q.s3) | (st_q.stable & (st_q.s2 | st_q.s3));
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign level = st_q.stable;

endmodule : gpc_pin_sync

// ---- sim/gpc_props.sv ----
// Port checker for the pin configuration bank.
// Assumes it is bound to gpc_top.
`timescale 1ns/1ps
module gpc_props
  import gpc_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [DATA_W-1:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [PIN_COUNT-1:0] pin_irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  ////////////////////
  property p_wr_ans;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid;
  endproperty
  a_wr_ans: assert property (p_wr_ans) else $error("no write answer");
  property p_rd_ans;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("no read answer");
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
  property p_aw_wait;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_aw_wait: assert property (p_aw_wait) else $error("write taken too early");
  property p_ar_wait;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_ar_wait: assert property (p_ar_wait) else $error("read taken too early");
  property p_unmapped;
    s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h10 |=>
      s_axi_rdata == 32'h0000_0000 && s_axi_rresp == RESP_SLVERR;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("bad unmapped read");
  property p_irq_pulse;
    pin_irq != '0 |=> (pin_irq & $past(pin_irq)) == '0;
  endproperty
  a_irq_pulse: assert property (p_irq_pulse) else $error("irq too long");
endmodule : gpc_props

bind gpc_top gpc_props i_gpc_props (.clk, .reset_n, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
  .pin_irq);

// ---- sim/gpc_pad_model.sv ----
// Pad model for pins 32 to 47.
// Assumes a pull-up on every pad; the outside driver yields to the bank.
`timescale 1ns/1ps
module gpc_pad_model
  import gpc_pkg::*;
(
  input wire logic [PIN_COUNT-1:0] pad_out,
  input wire logic [PIN_COUNT-1:0] pad_oe,
  input wire logic [PIN_COUNT-1:0] ext_en,
  input wire logic [PIN_COUNT-1:0] ext_val,
  output logic [PIN_COUNT-1:0] pad_in
);
  // Released pad rises to the pull-up level
  assign pad_in = (pad_oe & pad_out) | (~pad_oe & (~ext_en | ext_val));
endmodule : gpc_pad_model

// ---- sim/gpc_top_tb_top.sv ----
// Testbench for the pin configuration bank.
// Assumes gpc_top, gpc_pad_model and the bound checker.
`timescale 1ns/1ps
module gpc_top_tb_top
  import gpc_pkg::*;
;
  logic clk = 0;
  logic reset_n = 0;
  logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [DATA_W-1:0] s_axi_wdata = '0, s_axi_rdata;
  logic [STRB_W-1:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0;
  logic s_axi_bready = 1, s_axi_rready = 1;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, last_resp;
  logic [PIN_COUNT-1:0] pad_in, pad_out, pad_oe, pin_irq, ext_en = '0, ext_val = '0;
  int n_errors = 0, n_compared = 0;

  always #25 clk = ~clk;

  gpc_top i_gpc_top (.clk, .reset_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pad_in, .pad_out, .pad_oe, .pin_irq);
  gpc_pad_model i_gpc_pad_model (.pad_out, .pad_oe, .ext_en, .ext_val, .pad_in);
  ////////////////////
  task automatic conclude;
    $display("compared %0d, errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : conclude

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      n_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, s, e);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ra, rw, rb;
    int n;
    n = 0;
    rb = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    while (!rb) begin
      @(negedge clk);
      ra = (s_axi_awvalid & s_axi_awready) === 1'b1;
      rw = (s_axi_wvalid & s_axi_wready) === 1'b1;
      rb = s_axi_bvalid === 1'b1;
      if (rb) last_resp = s_axi_bresp;
      @(posedge clk);
      if (ra) s_axi_awvalid <= 0;
      if (rw) s_axi_wvalid <= 0;
      if (++n > 50) begin
        n_errors++;
        conclude();
      end
    end
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic ra, rv;
    int n;
    n = 0;
    rv = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    while (!rv) begin
      @(negedge clk);
      ra = (s_axi_arvalid & s_axi_arready) === 1'b1;
      rv = s_axi_rvalid === 1'b1;
      if (rv) chk(s_axi_rdata, e);
      last_resp = s_axi_rresp;
      @(posedge clk);
      if (ra) s_axi_arvalid <= 0;
      if (++n > 50) begin
        n_errors++;
        conclude();
      end
    end
  endtask : rd

  task automatic t_lock;
    rd(OFF_CFG_32_39, CFG_RESET);
    rd(OFF_CFG_40_47, CFG_RESET);
    chk(32'(pad_oe), 32'h0000_0000);
    wr(OFF_CFG_32_39, 32'hFFFF_FFFF);
    chk(32'(last_resp), 32'(RESP_OKAY));
    rd(OFF_CFG_32_39, CFG_RESET);
    wr(OFF_WRITE_KEY, UNLOCK_KEY);
    rd(OFF_WRITE_KEY, UNLOCK_KEY);
    wr(OFF_CFG_32_39, 32'h1234_5678);
    chk(32'(last_resp), 32'(RESP_OKAY));
    rd(OFF_CFG_32_39, 32'h1234_5678);
    wr(OFF_CFG_40_47, 32'h9ABC_DEF0);
    rd(OFF_CFG_40_47, 32'h9ABC_DEF0);
    wr(OFF_WRITE_KEY, KEY_RESET);
    wr(OFF_CFG_40_47, CFG_RESET);
    rd(OFF_CFG_40_47, 32'h9ABC_DEF0);
    wr(OFF_WRITE_KEY, UNLOCK_KEY);
    rd(8'h10, 32'h0000_0000);
    chk(32'(last_resp), 32'(RESP_SLVERR));
    $display("lock test done");
  endtask : t_lock

  task automatic t_drive;
    logic [31:0] m;
    int p;
    for (int k = 0; k < 2; k++) begin
      p = k * 15;
      m = 32'h0000_0001 << p;
      for (int c = 0; c < 4; c++) begin
        for (int d = 0; d < 2; d++) begin
          wr(OFF_DATA_UPPER, d ? m : 32'h0000_0000);
          wr(OFF_OE_UPPER, d ? 32'h0000_0000 : m);
          wr(k ? OFF_CFG_40_47 : OFF_CFG_32_39, 32'(c) << ((p % 8) * 4 + DRV_LSB));
          repeat (2) @(posedge clk);
          @(negedge clk);
          chk(32'(pad_out[p]), 32'((c == 1 || c == 3) && d));
          chk(32'(pad_oe[p]), 32'(c == 1 || (c > 1 && !d)));
          @(posedge clk);
        end
      end
    end
    wr(OFF_CFG_40_47, CFG_RESET);
    $display("drive test done");
  endtask : t_drive

  task automatic pulses(input logic v, input int e);
    int c;
    c = 0;
    ext_val[0] <= v;
    repeat (12) begin
      @(negedge clk);
      if (pin_irq[0] === 1'b1) c++;
      @(posedge clk);
    end
    chk(c, e);
  endtask : pulses

  task automatic t_input;
    wr(OFF_CFG_32_39, CFG_RESET);
    ext_en <= 16'hFFFF;
    ext_val <= 16'hA5C3;
    repeat (8) @(posedge clk);
    rd(OFF_READ_UPPER, 32'h0000_A5C3);
    wr(OFF_CFG_32_39, 32'h1111_1111);
    rd(OFF_READ_UPPER, 32'h0000_A500);
    pulses(0, 0);
    pulses(1, 1);
    wr(OFF_CFG_32_39, 32'h0000_0008);
    pulses(0, 1);
    pulses(1, 0);
    $display("input test done");
  endtask : t_input

  initial begin
    repeat (16) @(posedge clk);
    reset_n <= 1;
    @(posedge clk);
    t_lock();
    t_drive();
    t_input();
    conclude();
  end
endmodule : gpc_top_tb_top
